// ---- mpe_pkg.sv ----
// package: shared types and constants for the motion program error checker
package mpe_pkg;

  // task error codes, BCD as shown to the host
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_OVERFLOW = 16'h0029;
  localparam logic [15:0] ERR_ZERO_DIV = 16'h0030;
  localparam logic [15:0] ERR_POSITION = 16'h0031;
  localparam logic [15:0] ERR_REGISTER = 16'h0032;
  localparam logic [15:0] ERR_NESTING = 16'h0034;
  localparam logic [15:0] ERR_NO_CALLER = 16'h0035;
  localparam logic [15:0] ERR_UNSELECTED = 16'h0036;
  localparam logic [15:0] ERR_NUM_RANGE = 16'h0037;
  localparam logic [15:0] ERR_SPEED = 16'h0038;
  localparam logic [15:0] ERR_CORRUPT = 16'h0039;

  // nesting limit for subprogram jumps
  localparam logic [2:0] NEST_MAX = 3'h5;
  localparam logic [2:0] NEST_RESET = 3'h0;

  // function codes of the intermediate program
  typedef enum logic [3:0] {
    MPE_FN_NOP = 4'h0,
    MPE_FN_POSITION = 4'h1,
    MPE_FN_ARITH = 4'h2,
    MPE_FN_SUBST = 4'h3,
    MPE_FN_JUMP = 4'h4,
    MPE_FN_SUBEND = 4'h5,
    MPE_FN_NUMERIC = 4'h6,
    MPE_FN_INTERP = 4'h7,
    MPE_FN_END = 4'h8
  } mpe_fn_e;

  // one executed function with its check results from the datapath
  typedef struct packed {
    logic valid;
    logic [3:0] code;
    logic conv_overflow;
    logic div_zero;
    logic pos_range;
    logic no_origin;
    logic reg_range;
    logic num_range;
    logic speed_nonpos;
  } mpe_func_s;

  // host command bits, raw from the host; mpe_sync synchronises them
  typedef struct packed {
    logic prog_read;
    logic cycle_start;
    logic error_reset;
    logic prog_changed;
  } mpe_cmd_s;

  // interpreter status toward the host
  typedef struct packed {
    logic running;
    logic error;
    logic [15:0] error_code;
  } mpe_stat_s;

endpackage

// ---- mpe_sync.sv ----
// two-flop synchroniser for the host command bits
`timescale 1ns/1ps
module mpe_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire mpe_pkg::mpe_cmd_s din,
  output mpe_pkg::mpe_cmd_s dout
);

  // all state in one struct: two stages
  typedef struct packed {
    mpe_pkg::mpe_cmd_s meta;
    mpe_pkg::mpe_cmd_s stable;
  } mpe_sync_s;

  mpe_sync_s st; // registered state
  mpe_sync_s next_st; // next state

  ////////////////////////////////////////////////////////////////////
  // next state: first stage feeds only the second
  always_comb begin
    next_st.meta = din;
    next_st.stable = st.meta;
  end

  // register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stable;

endmodule // mpe_sync

// ---- mpe_checker.sv ----
// top: task error checker of the motion program interpreter
//
// Overview of operation
// - conversion overflow in positioning raises 0029
// - arithmetic divide by zero raises 0030
// - arithmetic result out of range raises 0031
// - substituting position without origin raises 0031
// - register out of range raises 0032
// - sixth nested subprogram jump raises 0034
// - subprogram end without caller raises 0035 in a run started from a subprogram
// - start without program read refused, 0036
// - numeric operand out of range raises 0037
// - offset or preset conversion overflow raises 0037
// - zero or negative interpolation speed raises 0038
// - unknown intermediate code raises 0039
`timescale 1ns/1ps
module mpe_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire mpe_pkg::mpe_cmd_s host_cmd,
  input wire logic start_is_sub,
  input wire mpe_pkg::mpe_func_s func,
  output mpe_pkg::mpe_stat_s status,
  output logic func_ready
);

  typedef enum logic [1:0] {
    MPE_IDLE,
    MPE_RUN,
    MPE_FAULT
  } mpe_state_e;

  // all state of the module
  typedef struct packed {
    mpe_state_e state;
    logic armed; // program number read since last edit
    logic from_sub; // started directly from a subprogram
    logic [2:0] depth; // current subprogram nesting
    logic start_q; // cycle start edge detector
    logic read_q; // program read edge detector
    logic reset_q; // error reset edge detector
    mpe_pkg::mpe_stat_s stat;
    logic ready;
  } mpe_chk_s;

  mpe_chk_s st; // registered state
  mpe_chk_s next_st; // next state
  mpe_pkg::mpe_cmd_s cmd; // synchronised host bits
  logic start_rise; // cycle start rising edge
  logic read_rise; // program read rising edge
  logic reset_rise; // error reset rising edge
  logic [15:0] fault; // code of the function's first fault

  ////////////////////////////////////////////////////////////////////
  // host bits come from another unit: synchronise first
  mpe_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(host_cmd),
    .dout(cmd)
  );

  assign start_rise = cmd.cycle_start & ~st.start_q;
  assign read_rise = cmd.prog_read & ~st.read_q;
  assign reset_rise = cmd.error_reset & ~st.reset_q;

  ////////////////////////////////////////////////////////////////////
  // known function code check, used only by the fault decode
  function automatic logic known_code(input logic [3:0] c);
    known_code = (c <= mpe_pkg::MPE_FN_END);
  endfunction

  // classify one executed function into a task error code
  function automatic logic [15:0] classify(input mpe_pkg::mpe_func_s f,
                                           input logic [2:0] depth,
                                           input logic from_sub);
    classify = mpe_pkg::ERR_NONE;
    if (!known_code(f.code)) begin
      classify = mpe_pkg::ERR_CORRUPT;
    end else begin
      case (f.code)
        mpe_pkg::MPE_FN_POSITION: begin
          if (f.conv_overflow) classify = mpe_pkg::ERR_OVERFLOW;
        end
        mpe_pkg::MPE_FN_ARITH: begin
          if (f.div_zero) classify = mpe_pkg::ERR_ZERO_DIV;
          else if (f.reg_range) classify = mpe_pkg::ERR_REGISTER;
          else if (f.pos_range) classify = mpe_pkg::ERR_POSITION;
        end
        mpe_pkg::MPE_FN_SUBST: begin
          if (f.no_origin) classify = mpe_pkg::ERR_POSITION;
          else if (f.reg_range) classify = mpe_pkg::ERR_REGISTER;
        end
        mpe_pkg::MPE_FN_JUMP: begin
          if (depth >= mpe_pkg::NEST_MAX) classify = mpe_pkg::ERR_NESTING;
        end
        mpe_pkg::MPE_FN_SUBEND: begin
          // a subprogram started on its own has nowhere to return
          if (depth == mpe_pkg::NEST_RESET && from_sub) begin
            classify = mpe_pkg::ERR_NO_CALLER;
          end
        end
        mpe_pkg::MPE_FN_NUMERIC: begin
          // range and conversion overflow both report 0037
          if (f.num_range || f.conv_overflow) begin
            classify = mpe_pkg::ERR_NUM_RANGE;
          end
        end
        mpe_pkg::MPE_FN_INTERP: begin
          if (f.speed_nonpos) classify = mpe_pkg::ERR_SPEED;
          else if (f.conv_overflow) classify = mpe_pkg::ERR_OVERFLOW;
        end
        default: classify = mpe_pkg::ERR_NONE;
      endcase
    end
  endfunction

  assign fault = classify(func, st.depth, st.from_sub);

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    next_st.start_q = cmd.cycle_start;
    next_st.read_q = cmd.prog_read;
    next_st.reset_q = cmd.error_reset;
    // an edit disarms; a read in the same cycle still arms (set wins)
    if (cmd.prog_changed) next_st.armed = 1'b0;
    if (read_rise) next_st.armed = 1'b1;
    case (st.state)
      MPE_IDLE: begin
        next_st.ready = 1'b0;
        if (start_rise) begin
          if (st.armed || read_rise) begin
            next_st.state = MPE_RUN;
            next_st.from_sub = start_is_sub;
            next_st.depth = mpe_pkg::NEST_RESET;
            next_st.stat.running = 1'b1;
            next_st.ready = 1'b1;
          end else begin
            // refuse to start without a program number read
            next_st.state = MPE_FAULT;
            next_st.stat.error = 1'b1;
            next_st.stat.error_code = mpe_pkg::ERR_UNSELECTED;
          end
        end
      end
      MPE_RUN: begin
        if (func.valid && st.ready) begin
          if (fault != mpe_pkg::ERR_NONE) begin
            // stop and hold the code
            next_st.state = MPE_FAULT;
            next_st.stat.running = 1'b0;
            next_st.stat.error = 1'b1;
            next_st.stat.error_code = fault;
            next_st.ready = 1'b0;
          end else begin
            case (func.code)
              mpe_pkg::MPE_FN_JUMP: next_st.depth = st.depth + 3'h1;
              mpe_pkg::MPE_FN_SUBEND: begin
                if (st.depth != mpe_pkg::NEST_RESET) next_st.depth = st.depth - 3'h1;
                else begin
                  next_st.state = MPE_IDLE;
                  next_st.stat.running = 1'b0;
                  next_st.ready = 1'b0;
                end
              end
              mpe_pkg::MPE_FN_END: begin
                next_st.state = MPE_IDLE;
                next_st.stat.running = 1'b0;
                next_st.ready = 1'b0;
              end
              default: next_st.depth = st.depth;
            endcase
          end
        end
      end
      MPE_FAULT: begin
        next_st.ready = 1'b0;
        // code stays until the host resets the error
        if (reset_rise) begin
          next_st.state = MPE_IDLE;
          next_st.stat.error = 1'b0;
          next_st.stat.error_code = mpe_pkg::ERR_NONE;
        end
      end
      default: next_st.state = MPE_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.state <= MPE_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign status = st.stat;
  assign func_ready = st.ready;

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_div_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    (st.state == MPE_RUN && st.ready && func.valid && func.code == mpe_pkg::MPE_FN_ARITH
     && func.div_zero) |=> (status.error_code == 16'h0030 && st.state == MPE_FAULT);
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("divide by zero not flagged");

  property p_overflow;
    @(posedge ref_clk) disable iff (!rst_n)
    (st.state == MPE_RUN && st.ready && func.valid && func.code == mpe_pkg::MPE_FN_POSITION
     && func.conv_overflow) |=> status.error_code == 16'h0029;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_pos_range;
    @(posedge ref_clk) disable iff (!rst_n)
    (st.state == MPE_RUN && st.ready && func.valid && func.code == mpe_pkg::MPE_FN_ARITH
     && !func.div_zero && !func.reg_range && func.pos_range) |=> status.error_code == 16'h0031;
  endproperty
  a_pos_range: assert property (p_pos_range) else $error("position range missed");

  property p_no_origin;
    @(posedge ref_clk) disable iff (!rst_n)
    (st.state == MPE_RUN && st.ready && func.valid && func.code == mpe_pkg::MPE_FN_SUBST
     && func.no_origin) |=> status.error_code == 16'h0031;
  endproperty
  a_no_origin: assert property (p_no_origin) else $error("origin fault missed");

  property p_nesting;
    @(posedge ref_clk) disable iff (!rst_n)
    (st.state == MPE_RUN && st.ready && func.valid && func.code == mpe_pkg::MPE_FN_JUMP
     && st.depth == 3'h5) |=> status.error_code == 16'h0034;
  endproperty
  a_nesting: assert property (p_nesting) else $error("sixth nesting not caught");

  property p_depth_limit;
    @(posedge ref_clk) disable iff (!rst_n) st.depth <= 3'h5;
  endproperty
  a_depth_limit: assert property (p_depth_limit) else $error("nesting above five");

  sequence s_unarmed_start;
    st.state == MPE_IDLE && start_rise && !st.armed && !read_rise;
  endsequence
  property p_unselected;
    @(posedge ref_clk) disable iff (!rst_n)
    s_unarmed_start |=> (!status.running && status.error_code == 16'h0036);
  endproperty
  a_unselected: assert property (p_unselected) else $error("unarmed start accepted");

  property p_speed;
    @(posedge ref_clk) disable iff (!rst_n)
    (st.state == MPE_RUN && st.ready && func.valid && func.code == mpe_pkg::MPE_FN_INTERP
     && func.speed_nonpos) |=> status.error_code == 16'h0038;
  endproperty
  a_speed: assert property (p_speed) else $error("bad speed accepted");

  property p_corrupt;
    @(posedge ref_clk) disable iff (!rst_n)
    (st.state == MPE_RUN && st.ready && func.valid && func.code > 4'h8)
      |=> status.error_code == 16'h0039;
  endproperty
  a_corrupt: assert property (p_corrupt) else $error("corrupt code missed");

  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    (status.error && !reset_rise) |=> (status.error && $stable(status.error_code)
      && !status.running);
  endproperty
  a_hold: assert property (p_hold) else $error("error code not held");

endmodule // mpe_checker

// ---- mpe_host_model.sv ----
// host model: controller ladder program driving the interpreter command bits
`timescale 1ns/1ps
module mpe_host_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  output mpe_pkg::mpe_cmd_s host_cmd
);
  // bit masks of the four command levels
  localparam mpe_pkg::mpe_cmd_s READ_BIT = 4'h8;
  localparam mpe_pkg::mpe_cmd_s START_BIT = 4'h4;
  localparam mpe_pkg::mpe_cmd_s CLEAR_BIT = 4'h2;
  localparam mpe_pkg::mpe_cmd_s EDIT_BIT = 4'h1;

  // all command levels low at power up
  initial begin
    host_cmd = 4'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one level high for four cycles, then low three: outlasts the two-flop sync
  task automatic pulse(input mpe_pkg::mpe_cmd_s m);
    // a level raised in reset would be lost in the cleared sync flops
    wait (rst_n);
    @(posedge ref_clk);
    host_cmd <= host_cmd | m;
    repeat (4) @(posedge ref_clk);
    host_cmd <= host_cmd & ~m;
    repeat (3) @(posedge ref_clk);
  endtask

  // program number read, then cycle start; skip only when a scenario asks
  task automatic start_prog(input logic skip_read);
    if (!skip_read) begin
      pulse(READ_BIT);
    end
    pulse(START_BIT);
  endtask

  // program edited from the tool side: disarms until the next read
  task automatic edit();
    pulse(EDIT_BIT);
  endtask

  // error reset level from the ladder
  task automatic clear_err();
    pulse(CLEAR_BIT);
  endtask
endmodule // mpe_host_model

// ---- mpe_checker_bench.sv ----
// testbench: self-checking run of the task error checker
`timescale 1ns/1ps
`define MPE_CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("BAD %0t saw %h wanted %h", $time, got, exp); \
  end \
end
module mpe_checker_bench;
  logic ref_clk; // 250 MHz
  logic rst_n; // active low reset
  logic start_is_sub; // selected program is a subprogram
  mpe_pkg::mpe_func_s func; // function under execution
  mpe_pkg::mpe_cmd_s host_cmd; // from the host model
  mpe_pkg::mpe_stat_s status; // interpreter status
  logic func_ready; // accepting functions
  int n_mismatch;
  int comparisons;
  int seed;
  // case table: {sub, code, conv,div,pos,origin,reg,num,speed}
  logic [11:0] cases [15] = '{
    {1'b0, 4'h1, 7'h40}, {1'b0, 4'h7, 7'h40},
    {1'b0, 4'h2, 7'h20}, {1'b0, 4'h2, 7'h24},
    {1'b0, 4'h2, 7'h10}, {1'b0, 4'h3, 7'h08}, {1'b0, 4'h3, 7'h0C},
    {1'b0, 4'h2, 7'h14}, {1'b0, 4'h3, 7'h04},
    {1'b0, 4'h6, 7'h02}, {1'b0, 4'h6, 7'h40},
    {1'b0, 4'h7, 7'h01}, {1'b0, 4'h7, 7'h41},
    {1'b1, 4'h5, 7'h00}, {1'b0, 4'h8, 7'h00}};
  logic [3:0] clean_tab [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7};

  //////////////////////////////////////////////////////////////////////////////
  // clock, design and host model
  always #2 ref_clk = ~ref_clk;

  mpe_checker u_dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .host_cmd(host_cmd),
    .start_is_sub(start_is_sub),
    .func(func),
    .status(status),
    .func_ready(func_ready)
  );

  mpe_host_model u_host (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .host_cmd(host_cmd)
  );

  //////////////////////////////////////////////////////////////////////////////
  // expected task error for one function; priorities as the designer chose
  function automatic logic [15:0] exp_err(input logic [3:0] c, input logic [6:0] f,
                                          input logic sub);
    case (c)
      4'h1: return f[6] ? mpe_pkg::ERR_OVERFLOW : mpe_pkg::ERR_NONE;
      4'h2: return f[5] ? mpe_pkg::ERR_ZERO_DIV : f[2] ? mpe_pkg::ERR_REGISTER :
                   f[4] ? mpe_pkg::ERR_POSITION : mpe_pkg::ERR_NONE;
      4'h3: return f[3] ? mpe_pkg::ERR_POSITION : f[2] ? mpe_pkg::ERR_REGISTER :
                   mpe_pkg::ERR_NONE;
      4'h5: return sub ? mpe_pkg::ERR_NO_CALLER : mpe_pkg::ERR_NONE;
      4'h6: return (f[1] | f[6]) ? mpe_pkg::ERR_NUM_RANGE : mpe_pkg::ERR_NONE;
      4'h7: return f[0] ? mpe_pkg::ERR_SPEED : f[6] ? mpe_pkg::ERR_OVERFLOW :
                   mpe_pkg::ERR_NONE;
      4'h0, 4'h4, 4'h8: return mpe_pkg::ERR_NONE;
      default: return mpe_pkg::ERR_CORRUPT;
    endcase
  endfunction

  // present one function for a cycle; back to back when called in a row
  task automatic issue(input logic [3:0] c, input logic [6:0] f);
    @(posedge ref_clk);
    func <= {1'b1, c, f};
  endtask

  // drop valid and let the taking edge land
  task automatic idle();
    @(posedge ref_clk);
    func.valid <= 1'b0;
    #1;
  endtask

  // start, random clean prefix, one checked function, hold and clear
  task automatic run_case(input logic [11:0] e);
    logic [15:0] exp;
    int n;
    exp = exp_err(e[10:7], e[6:0], e[11]);
    n = $unsigned($random(seed)) % 4;
    @(posedge ref_clk);
    start_is_sub <= e[11];
    u_host.start_prog(1'b0);
    #1;
    `MPE_CHK({status.running, func_ready}, 2'b11)
    repeat (n) issue(clean_tab[$unsigned($random(seed)) % 6], 7'h00);
    issue(e[10:7], e[6:0]);
    idle();
    `MPE_CHK({status, func_ready}, {1'b0, exp != mpe_pkg::ERR_NONE, exp, 1'b0})
    issue(4'hF, 7'h00); // ignored while stopped
    idle();
    repeat (3) @(posedge ref_clk);
    `MPE_CHK(status.error_code, exp)
    if (exp != mpe_pkg::ERR_NONE) begin
      u_host.clear_err();
    end
    #1;
    `MPE_CHK(status, 18'h00000)
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // verdict and end of run, shared with the watchdog
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog: run needs under two thousand cycles, allow far more
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end

  // main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    start_is_sub = 1'b0;
    func = 12'h000;
    n_mismatch = 0;
    comparisons = 0;
    seed = 32'h9FC72E41;
    @(posedge ref_clk);
    #1;
    `MPE_CHK({status, func_ready}, 19'h00000) // quiet in reset
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    // start with no read after reset: refused
    u_host.start_prog(1'b1);
    #1;
    `MPE_CHK(status, {2'b01, mpe_pkg::ERR_UNSELECTED})
    u_host.clear_err();
    // every table entry, then unknown codes, then random picks
    for (int i = 0; i < 15; i++) begin
      run_case(cases[i]);
    end
    for (int c = 9; c < 16; c++) begin
      run_case({1'b0, 4'(c), 7'h00});
    end
    repeat (20) run_case(cases[$unsigned($random(seed)) % 15]);
    // nesting: five levels fine, return, back to five, sixth refused
    start_is_sub <= 1'b0;
    u_host.start_prog(1'b0);
    repeat (5) issue(4'h4, 7'h00);
    issue(4'h5, 7'h00);
    issue(4'h4, 7'h00);
    idle();
    `MPE_CHK({status.running, status.error}, 2'b10)
    issue(4'h4, 7'h00);
    idle();
    `MPE_CHK(status, {2'b01, mpe_pkg::ERR_NESTING})
    u_host.clear_err();
    // edit after a read disarms; skipped read is refused again
    u_host.edit();
    u_host.start_prog(1'b1);
    #1;
    `MPE_CHK(status, {2'b01, mpe_pkg::ERR_UNSELECTED})
    // reset in mid-run: run stops at once and arming is lost
    u_host.clear_err();
    u_host.start_prog(1'b0);
    issue(4'h4, 7'h00);
    idle();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `MPE_CHK({status, func_ready}, 19'h00000)
    @(posedge ref_clk);
    rst_n <= 1'b1;
    u_host.start_prog(1'b1);
    #1;
    `MPE_CHK(status, {2'b01, mpe_pkg::ERR_UNSELECTED})
    end_sim();
  end
endmodule // mpe_checker_bench
